/* emp_pkg.sv */
// Constants and carrier types for the energy metering power path
package emp_pkg;
    // Clock and sample timing
    localparam int CLK_HZ     = 125_000_000;
    localparam int SAMPLE_HZ  = 7800;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    // Pulse output timing
    localparam int FULL_MS    = 180;
    localparam int HIGH_MS    = 90;
    localparam int CYC_FULL_MS = CLK_HZ / 1000 * FULL_MS;
    localparam int CYC_HIGH_MS = CLK_HZ / 1000 * HIGH_MS;
    // Energy per pulse: 1638.4 * 256 power-seconds, summed at SAMPLE_HZ
    localparam longint PULSE_NUM_X10 = 64'h4000;
    localparam longint ENERGY_QUANTUM = PULSE_NUM_X10 * 256 * SAMPLE_HZ / 10;
    // Data widths
    localparam int WAVE_W = 20;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 8;
    // Power scaling
    localparam int PROD_SHIFT = 16;
    localparam int LPF_SHIFT  = 3;
    localparam int STEP_FRAC  = 10;
    localparam logic signed [15:0] STEP_Q10 = 16'sh61A8;
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CUR_WAVE  = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_VOLT_WAVE = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_POWER     = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_CNT = 8'h0A;
    localparam logic [ADDR_W-1:0] ADDR_OFS       = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_THR       = 8'h17;
    // Reset values
    localparam logic [7:0] RST_OFS = 8'h00;
    localparam logic [7:0] RST_THR = 8'h0B;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } emp_reg_req_t;

    typedef struct packed {
        logic [15:0]              sample_cnt;
        logic                     tick;
        logic signed [WAVE_W-1:0] cur_wave;
        logic signed [WAVE_W-1:0] volt_wave;
        logic signed [DATA_W-1:0] avg;
        logic signed [DATA_W-1:0] power;
        logic                     noload;
        logic [DATA_W-1:0]        pulse_cnt;
        logic [7:0]               ofs;
        logic [7:0]               thr;
        logic [DATA_W-1:0]        rdata;
        logic [DATA_W-1:0]        rms;
    } emp_state_t;

    localparam emp_state_t STATE_RST = '{
        sample_cnt: 16'h0000, tick: 1'b0, cur_wave: 20'sh00000,
        volt_wave: 20'sh00000, avg: 24'sh000000, power: 24'sh000000,
        noload: 1'b0, pulse_cnt: 24'h000000, ofs: RST_OFS, thr: RST_THR,
        rdata: 24'h000000, rms: 24'h000000};

    typedef struct packed {
        logic signed [47:0] acc;
        logic               pos;
        logic               neg;
    } emp_int_state_t;

    typedef struct packed {
        logic [31:0] since;
        logic [31:0] high_left;
        logic        out;
    } emp_pout_state_t;
endpackage

/* emp_energy_int.sv */
// Energy integrator: sums power per sample, emits signed quantum pulses
`timescale 1ns/10ps
`default_nettype none
module emp_energy_int
    import emp_pkg::*;
#(
    parameter longint QUANTUM = ENERGY_QUANTUM
)(
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     reset_i,
    // Power samples
    input  wire logic                     step_i,
    input  wire logic signed [DATA_W-1:0] power_i,
    // Energy pulses
    output logic                          pos_o,
    output logic                          neg_o
);
    localparam logic signed [47:0] Q = 48'(QUANTUM);

    if (QUANTUM < 64'h100_0000 || QUANTUM > 64'h3FFF_FFFF_FFFF) begin : g_chk
        $error("QUANTUM must exceed one full-scale sample and fit the sum");
    end

    emp_int_state_t     s_reg;
    emp_int_state_t     s_next;
    logic signed [47:0] sum;

    assign sum = s_reg.acc + 48'(power_i);

    always_comb begin
        s_next     = s_reg;
        s_next.pos = 1'b0;
        s_next.neg = 1'b0;
        if (step_i) begin
            // One quantum per sample at most, since Q dwarfs any sample
            if (sum >= Q) begin
                s_next.acc = sum - Q;
                s_next.pos = 1'b1;
            end else if (sum <= -Q) begin
                s_next.acc = sum + Q;
                s_next.neg = 1'b1;
            end else begin
                s_next.acc = sum;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_reg <= '{acc: 48'sh0, pos: 1'b0, neg: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pos_o = s_reg.pos;
    assign neg_o = s_reg.neg;
endmodule
`default_nettype wire

/* emp_pulse_out.sv */
// Pulse shaper for the energy pulse output pin
`timescale 1ns/10ps
`default_nettype none
module emp_pulse_out
    import emp_pkg::*;
#(
    parameter int CYC_FULL = CYC_FULL_MS,
    parameter int CYC_HIGH = CYC_HIGH_MS
)(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // Pulse request and pin level
    input  wire logic event_i,
    output logic      pulse_o
);
    if (CYC_HIGH < 1 || CYC_FULL <= CYC_HIGH) begin : g_chk
        $error("CYC_FULL must exceed CYC_HIGH, both positive");
    end

    emp_pout_state_t s_reg;
    emp_pout_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (s_reg.since < 32'(CYC_FULL)) begin
            s_next.since = s_reg.since + 32'h1;
        end
        if (s_reg.high_left != 32'h0) begin
            s_next.high_left = s_reg.high_left - 32'h1;
        end
        if (event_i) begin
            s_next.since = 32'h1;
            // Short period: half of it, never past the fixed width
            if (s_reg.since >= 32'(CYC_FULL) || (s_reg.since >> 1) > 32'(CYC_HIGH)) begin
                s_next.high_left = 32'(CYC_HIGH);
            end else begin
                s_next.high_left = (s_reg.since > 32'h1) ? s_reg.since >> 1 : 32'h1;
            end
        end
        s_next.out = (s_next.high_left != 32'h0);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_reg <= '{since: 32'(CYC_FULL), high_left: 32'h0, out: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse_o = s_reg.out;

    a_pulse_rise: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        event_i |=> pulse_o) else $error("Pulse did not start");
    a_fixed_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        event_i && s_reg.since >= 32'(CYC_FULL) |=> s_reg.high_left == 32'(CYC_HIGH))
        else $error("Long period pulse width wrong");
endmodule
`default_nettype wire

/* emp_power_path.sv */
// Power and energy path: waveforms, active power, no-load gate, pulses
`timescale 1ns/10ps
`default_nettype none
module emp_power_path
    import emp_pkg::*;
#(
    parameter int     SAMPLE_DIV = SAMPLE_CYC,
    parameter int     CYC_FULL   = CYC_FULL_MS,
    parameter int     CYC_HIGH   = CYC_HIGH_MS,
    parameter longint QUANTUM    = ENERGY_QUANTUM
)(
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     reset_i,
    // Converter results on this clock
    input  wire logic signed [WAVE_W-1:0] cur_adc_i,
    input  wire logic signed [WAVE_W-1:0] volt_adc_i,
    input  wire logic [DATA_W-1:0]        cur_rms_i,
    // Register port from the serial front end
    input  wire emp_reg_req_t             reg_req_i,
    output logic [DATA_W-1:0]             reg_rdata_o,
    // Results
    output logic [DATA_W-1:0]             cur_rms_o,
    output logic                          noload_o,
    output logic                          energy_pulse_output_o
);
    if (SAMPLE_DIV < 16 || SAMPLE_DIV > 65536) begin : g_chk_div
        $error("SAMPLE_DIV must lie in 16..65536");
    end
    if (PROD_SHIFT + DATA_W > 2 * WAVE_W) begin : g_chk_shift
        $error("PROD_SHIFT too large for the product width");
    end

    emp_state_t s_reg;
    emp_state_t s_next;

    logic signed [2*WAVE_W-1:0] prod;
    logic signed [DATA_W-1:0]   inst;
    logic signed [DATA_W:0]     diff;
    logic signed [DATA_W-1:0]   ofs_prod;
    logic [DATA_W-1:0]          thr_prod;
    logic [DATA_W-1:0]          thr_term;
    logic signed [DATA_W:0]     corr;
    logic [DATA_W:0]            mag;
    logic signed [DATA_W-1:0]   sat;
    logic                       below;
    logic                       pos_pulse;
    logic                       neg_pulse;

    // Instantaneous power; the analog gain sets the 4046/Vref^2 scale
    assign prod = s_reg.cur_wave * s_reg.volt_wave;
    assign inst = prod[PROD_SHIFT+DATA_W-1:PROD_SHIFT];
    assign diff = (DATA_W+1)'(inst) - (DATA_W+1)'(s_reg.avg);

    // Offset: each unit moves the result by 8*3.05 counts (Q10 factor)
    assign ofs_prod = $signed(s_reg.ofs) * STEP_Q10;
    assign corr     = (DATA_W+1)'(s_reg.avg)
                    + (DATA_W+1)'(ofs_prod >>> STEP_FRAC);

    // Threshold in power counts, exact in Q10
    assign thr_prod = DATA_W'(s_reg.thr) * DATA_W'(STEP_Q10);
    assign thr_term = thr_prod >> STEP_FRAC;

    assign mag   = corr[DATA_W] ? (DATA_W+1)'(0) - corr : corr;
    assign below = mag < {1'b0, thr_term};

    // Clamp rather than wrap so a large offset never flips the sign
    always_comb begin
        if (corr[DATA_W] != corr[DATA_W-1]) begin
            sat = corr[DATA_W] ? 24'sh800000 : 24'sh7FFFFF;
        end else begin
            sat = corr[DATA_W-1:0];
        end
    end

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;

        // Sample rate divider
        if (s_reg.sample_cnt == 16'(SAMPLE_DIV - 1)) begin
            s_next.sample_cnt = 16'h0000;
            s_next.tick       = 1'b1;
        end else begin
            s_next.sample_cnt = s_reg.sample_cnt + 16'h0001;
        end

        // Latch a fresh sample pair, smooth the power product
        if (s_reg.tick) begin
            s_next.cur_wave  = cur_adc_i;
            s_next.volt_wave = volt_adc_i;
            s_next.avg       = s_reg.avg + DATA_W'(diff >>> LPF_SHIFT);
        end

        // Published power: corrected, then gated at no load
        s_next.noload = below;
        s_next.power  = below ? 24'sh000000 : sat;
        s_next.rms    = below ? 24'h000000 : cur_rms_i;

        // Signed running pulse count
        if (pos_pulse) begin
            s_next.pulse_cnt = s_reg.pulse_cnt + 24'h000001;
        end else if (neg_pulse) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 24'h000001;
        end

        // Register writes; result registers ignore writes
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ADDR_OFS: s_next.ofs = reg_req_i.wdata[7:0];
                ADDR_THR: s_next.thr = reg_req_i.wdata[7:0];
                default:  s_next.ofs = s_reg.ofs;
            endcase
        end

        // Register reads, answered on the next edge
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ADDR_CUR_WAVE: begin
                    s_next.rdata = {4'h0, s_reg.cur_wave};
                end
                ADDR_VOLT_WAVE: begin
                    s_next.rdata = {4'h0, s_reg.volt_wave};
                end
                ADDR_POWER:     s_next.rdata = s_reg.power;
                ADDR_PULSE_CNT: s_next.rdata = s_reg.pulse_cnt;
                ADDR_OFS:       s_next.rdata = {16'h0000, s_reg.ofs};
                ADDR_THR:       s_next.rdata = {16'h0000, s_reg.thr};
                default:        s_next.rdata = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Energy integration, one step per sample
    emp_energy_int #(
        .QUANTUM (QUANTUM)
    ) u_int (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .step_i    (s_reg.tick),
        .power_i   (s_reg.power),
        .pos_o     (pos_pulse),
        .neg_o     (neg_pulse)
    );

    // Pin pulse for either sign of energy
    emp_pulse_out #(
        .CYC_FULL (CYC_FULL),
        .CYC_HIGH (CYC_HIGH)
    ) u_pout (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .event_i   (pos_pulse | neg_pulse),
        .pulse_o   (energy_pulse_output_o)
    );

    assign reg_rdata_o = s_reg.rdata;
    assign cur_rms_o   = s_reg.rms;
    assign noload_o    = s_reg.noload;

    // Sample timing and waveform registers
    a_wave_refresh: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.tick |=> s_reg.cur_wave == $past(cur_adc_i)
                    && s_reg.volt_wave == $past(volt_adc_i))
        else $error("Waveform sample not latched on tick");

    a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.tick |=> !s_reg.tick [*8])
        else $error("Sample ticks too close");

    a_tick_phase: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.tick |-> s_reg.sample_cnt == 16'h0000)
        else $error("Sample tick off its divider phase");

    a_wave_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !s_reg.tick |=> $stable(s_reg.cur_wave) && $stable(s_reg.volt_wave))
        else $error("Waveform changed between ticks");

    a_wave_upper: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.rd && (reg_req_i.addr == ADDR_CUR_WAVE
                      || reg_req_i.addr == ADDR_VOLT_WAVE)
        |=> s_reg.rdata[23:20] == 4'h0)
        else $error("Waveform upper bits not zero");

    // Offset and threshold scaling
    a_offset_neutral: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.ofs == 8'h00 |-> corr == (DATA_W+1)'(s_reg.avg))
        else $error("Zero offset moved the power");

    a_offset_sign: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.ofs[7] |-> corr < (DATA_W+1)'(s_reg.avg))
        else $error("Negative offset did not lower the power");

    a_offset_gain: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !s_reg.ofs[7] |-> corr - (DATA_W+1)'(s_reg.avg) >= (DATA_W+1)'(s_reg.ofs) * 25'h18
                       && corr - (DATA_W+1)'(s_reg.avg) <= (DATA_W+1)'(s_reg.ofs) * 25'h19)
        else $error("Offset step outside 24 to 25 counts");

    a_thr_scale: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        thr_term >= DATA_W'(s_reg.thr) * 24'h000018
        && thr_term <= DATA_W'(s_reg.thr) * 24'h000019)
        else $error("Threshold step outside 24 to 25 counts");

    // No-load gate and published power
    a_noload_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        noload_o |-> s_reg.power == 24'sh000000)
        else $error("Power not zero at no load");

    a_gate_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        below |=> s_reg.power == 24'sh000000)
        else $error("Power below threshold not forced");

    a_rms_forced: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        below |=> cur_rms_o == 24'h000000 && noload_o)
        else $error("Current RMS not forced at no load");

    a_load_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !below |=> !noload_o && cur_rms_o == $past(cur_rms_i))
        else $error("Current RMS not passed under load");

    a_sat_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !below && !corr[DATA_W] && corr[DATA_W-1] |=> s_reg.power == 24'sh7FFFFF)
        else $error("Positive overflow not clamped");

    a_sat_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        corr[DATA_W] && !corr[DATA_W-1] |=> s_reg.power == 24'sh800000)
        else $error("Negative overflow not clamped");

    a_neg_power: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !below && corr[DATA_W] && corr[DATA_W-1]
        |=> s_reg.power == $past(corr[DATA_W-1:0]))
        else $error("Negative power not published");

    a_power_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !below && !corr[DATA_W] && corr[DATA_W-1] == 1'b0
        |=> s_reg.power == $past(corr[DATA_W-1:0]))
        else $error("Power register not the corrected value");

    // Register port
    a_reset_values: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $past(reset_i) |-> s_reg.ofs == RST_OFS && s_reg.thr == RST_THR
                        && s_reg.power == 24'sh000000)
        else $error("Wrong register reset values");

    a_ofs_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == ADDR_OFS
        |=> s_reg.ofs == $past(reg_req_i.wdata[7:0]))
        else $error("Offset write lost");

    a_thr_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == ADDR_THR
        |=> s_reg.thr == $past(reg_req_i.wdata[7:0]))
        else $error("Threshold write lost");

    a_ro_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr != ADDR_OFS && reg_req_i.addr != ADDR_THR
        |=> $stable(s_reg.ofs) && $stable(s_reg.thr))
        else $error("Write to a result register took effect");

    a_read_power: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.rd && reg_req_i.addr == ADDR_POWER |=> reg_rdata_o == $past(s_reg.power))
        else $error("Power read returned wrong value");

    a_read_count: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_req_i.rd && reg_req_i.addr == ADDR_PULSE_CNT
        |=> reg_rdata_o == $past(s_reg.pulse_cnt))
        else $error("Pulse count read returned wrong value");

    // Energy pulses and their count
    a_count_up: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pos_pulse |=> s_reg.pulse_cnt == $past(s_reg.pulse_cnt) + 24'h000001)
        else $error("Pulse count did not increment");

    a_count_down: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        neg_pulse |=> s_reg.pulse_cnt == $past(s_reg.pulse_cnt) - 24'h000001)
        else $error("Pulse count did not decrement");

    a_count_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !pos_pulse && !neg_pulse |=> $stable(s_reg.pulse_cnt))
        else $error("Pulse count moved without a pulse");

    a_pulse_tick: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pos_pulse || neg_pulse |-> $past(s_reg.tick))
        else $error("Energy pulse without a sample step");

    c_sample_tick: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        s_reg.tick);
    c_pos_pulse: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        pos_pulse);
    c_neg_pulse: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        neg_pulse);
    c_noload_leave: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(noload_o));
endmodule
`default_nettype wire

/* emp_host_model.sv */
// Host model: register reads and writes on the parallel request port
`timescale 1ns/10ps
`default_nettype none
module emp_host_model
    import emp_pkg::*;
(
    // Clock and read data
    input  wire logic              sys_clk_i,
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    // Register request
    output var emp_reg_req_t       reg_req_o
);
    initial reg_req_o = '0;

    // Request set at a falling edge, held across one rising edge
    task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
        @(negedge sys_clk_i);
        reg_req_o = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge sys_clk_i);
        reg_req_o = '0;
    endtask

    // Each read holds its request for one cycle and leaves one idle cycle, fast enough to see every sample
    task automatic read_reg(input logic [7:0] addr, output logic [23:0] data);
        @(negedge sys_clk_i);
        reg_req_o = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 24'h000000};
        @(negedge sys_clk_i);
        reg_req_o = '0;
        data = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

/* emp_power_path_tb.sv */
// Testbench for the power path: registers, no-load gate, energy pulses
`timescale 1ns/10ps
`default_nettype none
module emp_power_path_tb
    import emp_pkg::*;
();
    localparam int     DIV  = 32;
    localparam int     FULL = 200;
    localparam int     HIGH = 90;
    localparam longint Q    = 64'h1000000;

    logic                     sys_clk_i;
    logic                     reset_i;
    logic signed [WAVE_W-1:0] cur_adc;
    logic signed [WAVE_W-1:0] volt_adc;
    logic [DATA_W-1:0]        cur_rms;
    emp_reg_req_t             req;
    logic [DATA_W-1:0]        rdata;
    logic [DATA_W-1:0]        rms_out;
    logic                     noload;
    logic                     pin;
    logic                     pin_q;
    logic [23:0]              v;
    int                       num_errors;
    int                       cmp_count;
    int                       cyc;
    int                       last_rise;
    int                       per;
    int                       rises;
    int                       k0;
    longint                   p;
    logic [7:0]               addrs [7] = '{8'h01, 8'h03, 8'h08, 8'h0A, 8'h15, 8'h17, 8'h02};
    logic [23:0]              rstv  [7] = '{'0, '0, '0, '0, '0, 24'h00000B, '0};

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    emp_power_path #(.SAMPLE_DIV(DIV), .CYC_FULL(FULL), .CYC_HIGH(HIGH), .QUANTUM(Q))
    emp_power_path_inst (
        .sys_clk_i             (sys_clk_i),
        .reset_i               (reset_i),
        .cur_adc_i             (cur_adc),
        .volt_adc_i            (volt_adc),
        .cur_rms_i             (cur_rms),
        .reg_req_i             (req),
        .reg_rdata_o           (rdata),
        .cur_rms_o             (rms_out),
        .noload_o              (noload),
        .energy_pulse_output_o (pin)
    );

    emp_host_model emp_host_model_inst (
        .sys_clk_i   (sys_clk_i),
        .reg_rdata_i (rdata),
        .reg_req_o   (req)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Filtered values settle over many samples, so poll under a bound
    task automatic poll(input logic [7:0] addr, input int lo, input int hi);
        int n;
        for (n = 0; n < 2500; n++) begin
            emp_host_model_inst.read_reg(addr, v);
            if ($signed(v) >= lo && $signed(v) <= hi)
                break;
        end
        cmp_count++;
        if (n == 2500) begin
            num_errors++;
            $display("mismatch reg_%h expected %0d..%0d seen %h", addr, lo, hi, v);
            close_out();
        end
    endtask

    function automatic logic [23:0] width_exp(input int period);
        if (period >= FULL || period / 2 > HIGH)
            return 24'(HIGH);
        return 24'(period / 2);
    endfunction

    // Pin watcher: period from rise to rise, high time checked at the fall
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (pin === 1'b1 && pin_q === 1'b0) begin
            per = (last_rise < 0) ? FULL : cyc - last_rise;
            last_rise = cyc;
            rises = rises + 1;
        end
        if (pin === 1'b0 && pin_q === 1'b1)
            check("high_time", width_exp(per), 24'(cyc - last_rise));
        pin_q = pin;
    end

    initial begin
        cur_adc = '0;
        volt_adc = '0;
        cur_rms = 24'h123456;
        reset_i = 1'b1;
        pin_q = 1'b0;
        cyc = 0;
        last_rise = -1;
        rises = 0;
        num_errors = 0;
        cmp_count = 0;
        repeat (20) @(negedge sys_clk_i);
        reset_i = 1'b0;
        // Writes to a read-only and an unmapped place must not stick
        emp_host_model_inst.write_reg(ADDR_POWER, 24'h00ABCD);
        emp_host_model_inst.write_reg(8'h02, 24'h0000FF);
        for (int i = 0; i < 7; i++) begin
            emp_host_model_inst.read_reg(addrs[i], v);
            check("reset_value", rstv[i], v);
        end
        check("noload_idle", 24'h000001, 24'(noload));
        check("rms_gated", 24'h000000, rms_out);
        emp_host_model_inst.write_reg(ADDR_THR, 24'h000000);
        repeat (4) @(negedge sys_clk_i);
        check("noload_off", 24'h000000, 24'(noload));
        check("rms_pass", 24'h123456, rms_out);
        // Sign bit of each waveform, upper nibble zero
        cur_adc = 20'sh80001;
        poll(ADDR_CUR_WAVE, 'h080001, 'h080001);
        cur_adc = '0;
        volt_adc = 20'sh80001;
        poll(ADDR_VOLT_WAVE, 'h080001, 'h080001);
        // Full-scale positive power, pulses faster than the long period
        cur_adc = 20'sh7FFFF;
        volt_adc = 20'sh7FFFF;
        poll(ADDR_POWER, 'h3FFFE9, 'h3FFFF0);
        emp_host_model_inst.read_reg(ADDR_POWER, v);
        p = longint'(v);
        k0 = rises;
        repeat (64 * DIV) @(negedge sys_clk_i);
        p = 64 * p / Q - (rises - k0);
        check("pulse_rate", 24'h000001, 24'(p >= -1 && p <= 1));
        cur_adc = '0;
        volt_adc = '0;
        // Offset and threshold boundary with zero input
        emp_host_model_inst.write_reg(ADDR_OFS, 24'h000008);
        emp_host_model_inst.read_reg(ADDR_OFS, v);
        check("ofs_readback", 24'h000008, v);
        poll(ADDR_POWER, 'h0000C3, 'h0000C3);
        emp_host_model_inst.write_reg(ADDR_THR, 24'h000008);
        repeat (2 * DIV) @(negedge sys_clk_i);
        emp_host_model_inst.read_reg(ADDR_POWER, v);
        check("at_threshold", 24'h0000C3, v);
        emp_host_model_inst.write_reg(ADDR_THR, 24'h000009);
        poll(ADDR_POWER, 0, 0);
        emp_host_model_inst.write_reg(ADDR_OFS, 24'h0000F8);
        emp_host_model_inst.write_reg(ADDR_THR, 24'h000000);
        poll(ADDR_POWER, -32'sh000000C4, -32'sh000000C4);
        emp_host_model_inst.write_reg(ADDR_OFS, 24'h000000);
        emp_host_model_inst.write_reg(ADDR_THR, 24'h00000B);
        poll(ADDR_POWER, 0, 0);
        emp_host_model_inst.read_reg(ADDR_PULSE_CNT, v);
        check("count_up", 24'(rises), v);
        // Full-scale negative power counts down
        k0 = rises;
        p = longint'(v);
        cur_adc = 20'sh80001;
        volt_adc = 20'sh7FFFF;
        poll(ADDR_POWER, -32'sh003FFFF1, -32'sh003FFFF1);
        repeat (64 * DIV) @(negedge sys_clk_i);
        emp_host_model_inst.read_reg(ADDR_PULSE_CNT, v);
        check("count_down", 24'(p - (rises - k0)), v);
        check("neg_pulses", 24'h000001, 24'(rises > k0 + 8));
        close_out();
    end
endmodule
`default_nettype wire
